// *** common/ulc_pkg.sv ***
// Constants and carriers for the UART line control and status block
// Assumes a 32-bit APB master and a 100 MHz core clock
package ulc_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] ULC_OFF_DATA  = 8'h00;
   localparam logic [7:0] ULC_OFF_DIVHI = 8'h04;
   localparam logic [7:0] ULC_OFF_IEN   = 8'h08;
   localparam logic [7:0] ULC_OFF_LCR   = 8'h0c;
   localparam logic [7:0] ULC_OFF_LSR   = 8'h14;
   localparam logic [7:0] ULC_OFF_IRQST = 8'h20;
   localparam logic [7:0] ULC_OFF_IRQMK = 8'h24;
   // ==========================================================
   // Line control field positions
   localparam int ULC_LC_DLS  = 7;
   localparam int ULC_LC_BRK  = 6;
   localparam int ULC_LC_STK  = 5;
   localparam int ULC_LC_EVN  = 4;
   localparam int ULC_LC_PEN  = 3;
   localparam int ULC_LC_STOP = 2;
   // Line status field positions
   localparam int ULC_LS_TX_REG_EMPTY_FLAG = 6;
   localparam int ULC_LS_BOTH = 5;
   localparam int ULC_LS_BRK  = 4;
   localparam int ULC_LS_FE   = 3;
   localparam int ULC_LS_PE   = 2;
   localparam int ULC_LS_OE   = 1;
   localparam int ULC_LS_DR   = 0;
   // Interrupt enable field position
   localparam int ULC_IE_RLS  = 2;
   // ==========================================================
   // Reset values
   localparam logic [7:0]  ULC_LCR_RST = 8'h00;
   localparam logic [15:0] ULC_DIV_RST = 16'h0001;
   // Oversampling: sub-ticks per bit
   localparam int ULC_OVS = 16;
   // ==========================================================
   // Bit engine states (Gray order on main path)
   typedef enum logic [2:0] {
      ULC_IDLE  = 3'b000,
      ULC_START = 3'b001,
      ULC_DATA  = 3'b011,
      ULC_PAR   = 3'b010,
      ULC_STOP  = 3'b110
   } ulc_state_e;
   // Frame format decoded from line control
   typedef struct packed {
      logic [3:0] nbits;
      logic       parity_enable;
      logic       even;
      logic       stick;
      logic [5:0] stop_ticks;
   } ulc_fmt_s;
endpackage : ulc_pkg

// *** core/ulc_uart.sv ***
// UART line control and status with APB registers and serial pins
// Assumes synchronous APB, serial_input synchronous to ref_clk
//
// What this block does
// - Divisor select steers shared data address
// - Force break holds serial output low
// - Stick parity sends constant parity bit
// - Parity select chooses even or odd
// - Parity enable adds and checks parity
// - Long stop: 1.5 or 2 bits
// - Short stop: exactly one bit
// - Receiver checks only first stop bit
// - Length field selects 5 to 8 bits
// - Transmit empty flag, cleared by write
// - Both empty flag tracks tx and rx
// - Break flag on long low input
// - Framing flag on bad stop bit
// - Parity flag on parity mismatch
// - Overrun flag on unread overwrite
// - Data ready set, cleared by read
// - Status interrupt from error flags
`timescale 1ns/1ps
module ulc_uart
   import ulc_pkg::*;
#(
   parameter int DIV_W = 16
) (
   input  wire logic        ref_clk,       // Core clock
   input  wire logic        rst_n,         // Async reset, active low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB direction
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic        serial_input,  // Receive line
   output logic             serial_output, // Transmit line
   output logic             irq            // Interrupt, active high
);
   initial begin
      // High byte write uses bits DIV_W-1:8, so at least 9 bits
      if (DIV_W < 9 || DIV_W > 16) $error("DIV_W out of range");
   end
   // ==========================================================
   // Registers
   logic [7:0]       lcr_ff, ien_ff, msk_ff, sts_ff, rxd_ff, txd_ff;
   logic [DIV_W-1:0] div_ff;
   logic             dr_ff, oe_ff, pe_ff, fe_ff, bi_ff, thr_full_ff;
   logic [31:0]      prdata_ff;
   logic             pready_ff, pslverr_ff, serial_output_ff, irq_ff;
   // ==========================================================
   // APB decode
   wire acc    = psel && penable && !pready_ff;
   wire wr     = acc && pwrite;
   wire rd     = acc && !pwrite;
   wire dls    = lcr_ff[ULC_LC_DLS];
   wire hit_d  = paddr == ULC_OFF_DATA;
   wire wr_tx  = wr && hit_d && !dls;
   wire wr_dl  = wr && hit_d && dls;
   wire rd_rx  = rd && hit_d && !dls;
   wire wr_dh  = wr && paddr == ULC_OFF_DIVHI;
   wire wr_lcr = wr && paddr == ULC_OFF_LCR;
   wire wr_ien = wr && paddr == ULC_OFF_IEN;
   wire wr_msk = wr && paddr == ULC_OFF_IRQMK;
   wire rd_lsr = rd && paddr == ULC_OFF_LSR;
   wire rd_ist = rd && paddr == ULC_OFF_IRQST;
   wire mapped = hit_d || paddr == ULC_OFF_DIVHI || paddr == ULC_OFF_LCR
              || paddr == ULC_OFF_IEN || paddr == ULC_OFF_IRQMK
              || paddr == ULC_OFF_LSR || paddr == ULC_OFF_IRQST;
   // ==========================================================
   // Frame format
   ulc_fmt_s fmt;
   assign fmt.nbits = 4'd5 + {2'b00, lcr_ff[1:0]};
   assign fmt.parity_enable   = lcr_ff[ULC_LC_PEN];
   assign fmt.even  = lcr_ff[ULC_LC_EVN];
   assign fmt.stick = lcr_ff[ULC_LC_STK];
   assign fmt.stop_ticks = !lcr_ff[ULC_LC_STOP] ? 6'd16 :
                           (lcr_ff[1:0] == 2'b00) ? 6'd24 : 6'd32;
   // ==========================================================
   // Baud tick: one sixteenth of a bit
   logic [DIV_W-1:0] bdiv_ff;
   logic             tick_ff;
   wire [DIV_W-1:0]  div_eff = (div_ff == '0) ? DIV_W'(1) : div_ff;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bdiv_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (bdiv_ff + DIV_W'(1) >= div_eff);
         bdiv_ff <= (bdiv_ff + DIV_W'(1) >= div_eff) ? '0 : bdiv_ff + DIV_W'(1);
      end
   end
   // ==========================================================
   // Transmitter
   ulc_state_e tst_ff;
   logic [7:0] tsh_ff;
   logic [3:0] tbit_ff;
   logic [5:0] tsub_ff;
   logic       tpar_ff, tline_ff;
   wire        tbit_end = tick_ff && tsub_ff == 6'd15;
   wire        tx_busy  = tst_ff != ULC_IDLE;
   // Parity bit value, stick parity gives a constant
   wire        tx_par   = fmt.stick ? fmt.even : (tpar_ff ^ !fmt.even);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tst_ff <= ULC_IDLE;
         tsh_ff <= 8'h00;
         tbit_ff <= 4'h0;
         tsub_ff <= 6'h00;
         tpar_ff <= 1'b0;
         tline_ff <= 1'b1;
      end else begin
         tsub_ff <= tick_ff ? tsub_ff + 6'd1 : tsub_ff;
         case (tst_ff)
            ULC_IDLE: begin
               tline_ff <= 1'b1;
               tsub_ff <= 6'h00;
               if (thr_full_ff && tick_ff) begin
                  tst_ff <= ULC_START;
                  tsh_ff <= txd_ff;
                  tpar_ff <= 1'b0;
                  tline_ff <= 1'b0;
               end
            end
            ULC_START: begin
               if (tbit_end) begin
                  tst_ff <= ULC_DATA;
                  tsub_ff <= 6'h00;
                  tbit_ff <= 4'h0;
                  tline_ff <= tsh_ff[0];
               end
            end
            ULC_DATA: begin
               if (tbit_end) begin
                  tsub_ff <= 6'h00;
                  tpar_ff <= tpar_ff ^ tsh_ff[0];
                  tsh_ff <= {1'b0, tsh_ff[7:1]};
                  tbit_ff <= tbit_ff + 4'd1;
                  if (tbit_ff + 4'd1 == fmt.nbits) begin
                     tst_ff <= fmt.parity_enable ? ULC_PAR : ULC_STOP;
                     // Parity folds in the last data bit, no glitch on entry
                     tline_ff <= !fmt.parity_enable ? 1'b1 : fmt.stick ? fmt.even :
                                 (tpar_ff ^ tsh_ff[0] ^ !fmt.even);
                  end else begin
                     tline_ff <= tsh_ff[1];
                  end
               end
            end
            ULC_PAR: begin
               tline_ff <= tx_par;
               if (tbit_end) begin
                  tst_ff <= ULC_STOP;
                  tsub_ff <= 6'h00;
                  tline_ff <= 1'b1;
               end
            end
            ULC_STOP: begin
               // One tick early: the idle cycle completes the stop time
               if (tick_ff && tsub_ff + 6'd2 == fmt.stop_ticks) begin
                  tst_ff <= ULC_IDLE;
                  tsub_ff <= 6'h00;
               end
            end
            default: tst_ff <= ULC_IDLE;
         endcase
      end
   end
   // ==========================================================
   // Receiver
   ulc_state_e rst_ff;
   logic [7:0] rsh_ff;
   logic [3:0] rbit_ff;
   logic [3:0] rsub_ff;
   logic       rpar_ff, rperr_ff;
   logic [9:0] low_ff;
   logic       brk_seen_ff;
   wire        rsamp  = tick_ff && rsub_ff == 4'd7;
   wire        rb_end = tick_ff && rsub_ff == 4'd15;
   // Parity expected on the line
   wire        rx_exp = fmt.stick ? fmt.even : (rpar_ff ^ !fmt.even);
   wire        rx_done = rst_ff == ULC_STOP && rsamp;
   wire [7:0]  rx_char = rsh_ff >> (4'd8 - fmt.nbits);
   // Longest frame: start, 8 data, parity, 2 stop bits = 12 bits
   wire        brk_hit = low_ff >= 10'd192;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_ff <= ULC_IDLE;
         rsh_ff <= 8'h00;
         rbit_ff <= 4'h0;
         rsub_ff <= 4'h0;
         rpar_ff <= 1'b0;
         rperr_ff <= 1'b0;
      end else begin
         rsub_ff <= tick_ff ? rsub_ff + 4'd1 : rsub_ff;
         case (rst_ff)
            ULC_IDLE: begin
               rsub_ff <= 4'h0;
               if (!serial_input && !brk_seen_ff) rst_ff <= ULC_START;
            end
            ULC_START: begin
               if (rsamp) rst_ff <= serial_input ? ULC_IDLE : ULC_START;
               if (rb_end) begin
                  rst_ff <= ULC_DATA;
                  rbit_ff <= 4'h0;
                  rpar_ff <= 1'b0;
               end
            end
            ULC_DATA: begin
               if (rsamp) begin
                  rsh_ff <= {serial_input, rsh_ff[7:1]};
                  rpar_ff <= rpar_ff ^ serial_input;
               end
               if (rb_end) begin
                  rbit_ff <= rbit_ff + 4'd1;
                  if (rbit_ff + 4'd1 == fmt.nbits) rst_ff <= fmt.parity_enable ? ULC_PAR : ULC_STOP;
               end
            end
            ULC_PAR: begin
               if (rsamp) rperr_ff <= serial_input != rx_exp;
               if (rb_end) rst_ff <= ULC_STOP;
            end
            ULC_STOP: begin
               if (rsamp) rst_ff <= ULC_IDLE;
               if (!fmt.parity_enable) rperr_ff <= 1'b0;
            end
            default: rst_ff <= ULC_IDLE;
         endcase
      end
   end
   // Low-level duration for break detection
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_ff <= 10'h000;
         brk_seen_ff <= 1'b0;
      end else begin
         low_ff <= serial_input ? 10'h000 : (tick_ff && !brk_hit) ? low_ff + 10'd1 : low_ff;
         brk_seen_ff <= serial_input ? 1'b0 : (brk_hit || brk_seen_ff);
      end
   end
   // ==========================================================
   // Line status flags, hardware set beats read clear
   wire brk_ev = brk_hit && !brk_seen_ff;
   wire fe_ev  = rx_done && !serial_input && !brk_hit;
   wire pe_ev  = rx_done && rperr_ff && fmt.parity_enable;
   wire oe_ev  = rx_done && dr_ff && !rd_rx;
   logic [7:0] lsr;
   assign lsr = {1'b0, !thr_full_ff && !tx_busy, !thr_full_ff && !dr_ff,
                 bi_ff, fe_ff, pe_ff, oe_ff, dr_ff};
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dr_ff <= 1'b0;
         oe_ff <= 1'b0;
         pe_ff <= 1'b0;
         fe_ff <= 1'b0;
         bi_ff <= 1'b0;
         rxd_ff <= 8'h00;
         thr_full_ff <= 1'b0;
         txd_ff <= 8'h00;
      end else begin
         dr_ff <= rx_done || (dr_ff && !rd_rx);
         rxd_ff <= rx_done ? rx_char : rxd_ff;
         oe_ff <= oe_ev || (oe_ff && !rd_lsr);
         pe_ff <= pe_ev || (pe_ff && !rd_lsr);
         fe_ff <= fe_ev || (fe_ff && !rd_lsr);
         bi_ff <= brk_ev || (bi_ff && !rd_lsr);
         thr_full_ff <= wr_tx || (thr_full_ff && !(tst_ff == ULC_IDLE && tick_ff));
         txd_ff <= wr_tx ? pwdata[7:0] : txd_ff;
      end
   end
   // ==========================================================
   // Interrupt status, read to clear; set beats clear
   wire [7:0] ev = {4'h0, lsr[ULC_LS_TX_REG_EMPTY_FLAG] && thr_full_ff, brk_ev,
                    rx_done,
                    ien_ff[ULC_IE_RLS] && (oe_ev || pe_ev || fe_ev)};
   // ==========================================================
   // Control registers and bus answer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lcr_ff <= ULC_LCR_RST;
         ien_ff <= 8'h00;
         msk_ff <= 8'h00;
         sts_ff <= 8'h00;
         div_ff <= DIV_W'(ULC_DIV_RST);
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         serial_output_ff <= 1'b1;
         irq_ff <= 1'b0;
      end else begin
         lcr_ff <= wr_lcr ? pwdata[7:0] : lcr_ff;
         ien_ff <= wr_ien ? pwdata[7:0] : ien_ff;
         msk_ff <= wr_msk ? pwdata[7:0] : msk_ff;
         sts_ff <= ev | (rd_ist ? 8'h00 : sts_ff);
         if (wr_dl) div_ff[7:0] <= pwdata[7:0];
         if (wr_dh) div_ff[DIV_W-1:8] <= pwdata[DIV_W-1:8];
         pready_ff <= acc;
         pslverr_ff <= acc && !mapped;
         prdata_ff <= !rd ? 32'h0000_0000 :
                      hit_d ? {24'h0, dls ? div_ff[7:0] : rxd_ff} :
                      paddr == ULC_OFF_DIVHI ? {24'h0, 8'(div_ff >> 8)} :
                      paddr == ULC_OFF_LCR ? {24'h0, lcr_ff} :
                      paddr == ULC_OFF_IEN ? {24'h0, ien_ff} :
                      paddr == ULC_OFF_IRQMK ? {24'h0, msk_ff} :
                      paddr == ULC_OFF_LSR ? {24'h0, lsr} :
                      paddr == ULC_OFF_IRQST ? {24'h0, sts_ff} : 32'h0000_0000;
         serial_output_ff <= lcr_ff[ULC_LC_BRK] ? 1'b0 : tline_ff;
         irq_ff <= |((ev | sts_ff) & msk_ff);
      end
   end
   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;
   assign serial_output = serial_output_ff;
   assign irq           = irq_ff;
   // ==========================================================
   // Assertions
   a_break_holds_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      lcr_ff[ULC_LC_BRK] |=> !serial_output) else $error("break not low");
   a_tx_reg_empty_flag_clear_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_tx |=> !lsr[ULC_LS_TX_REG_EMPTY_FLAG]) else $error("tx empty after write");
   a_both_empty_rx: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_done |=> !lsr[ULC_LS_BOTH]) else $error("both empty after rx");
   a_dr_set_rx: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_done |=> dr_ff) else $error("data ready missing");
   a_dr_clear_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_rx && !rx_done |=> !dr_ff) else $error("data ready not cleared");
   a_overrun_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rx_done && dr_ff && !rd_rx |=> oe_ff) else $error("overrun missing");
   a_err_clear_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_lsr && !fe_ev && !pe_ev |=> !fe_ff && !pe_ff) else $error("errors not cleared");
   a_divisor_latch_select_no_tx: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr && hit_d && dls && !thr_full_ff |=> !thr_full_ff) else $error("tx write under dls");
   a_stick_par: assert property (@(posedge ref_clk) disable iff (!rst_n)
      tst_ff == ULC_PAR && fmt.stick && $stable(lcr_ff) && !lcr_ff[ULC_LC_BRK]
      |=> ##1 (tst_ff != ULC_PAR || serial_output == fmt.even)) else $error("stick parity");
   a_frame_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fe_ev |=> fe_ff) else $error("framing flag missing");
endmodule : ulc_uart

// *** verif/ulc_peer.sv ***
// Remote serial peer: drives the receive line, samples the transmit line
// Assumes one bit lasts 16 core clocks (divisor 1), line idles high
`timescale 1ns/1ps
module ulc_peer (
   input  wire logic ref_clk,       // Core clock
   input  wire logic serial_output, // Line from the block
   output logic      serial_input   // Line into the block
);
   int          nbits  = 8;   // Expected data bits
   int          parity_enable    = 0;   // Expected parity bit count
   int          nfr    = 0;   // Frames captured
   int          gap    = 0;   // Start-to-start cycles
   longint      t_last = 0;   // Time of last start edge
   logic [11:0] got;          // Sampled frame, start bit first
   initial serial_input = 1'b1;
   // ==========================================================
   // Capture each outgoing frame at mid-bit
   always begin
      @(negedge serial_output);
      gap = int'(($time - t_last) / 10);
      t_last = $time;
      got = '0;
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < nbits + parity_enable + 2; i++) begin
         got[i] = serial_output;
         if (i < nbits + parity_enable + 1) repeat (16) @(posedge ref_clk);
      end
      nfr++;
   end
   // ==========================================================
   // One bit held for 16 clocks
   task automatic drive(input logic b);
      @(posedge ref_clk);
      serial_input <= b;
      repeat (15) @(posedge ref_clk);
   endtask : drive
   // Frame: start, data LSB first, optional parity, one stop
   task automatic send(input logic [7:0] d, input int n, input int par, input logic stp);
      drive(1'b0);
      for (int i = 0; i < n; i++) drive(d[i]);
      if (par >= 0) drive(par[0]);
      drive(stp);
      serial_input <= 1'b1;
   endtask : send
   // Line held low, then back to idle high
   task automatic hold_low(input int c);
      @(posedge ref_clk);
      serial_input <= 1'b0;
      repeat (c) @(posedge ref_clk);
      serial_input <= 1'b1;
   endtask : hold_low
endmodule : ulc_peer

// *** verif/test_uart_line_control_status.sv ***
// Self-checking bench for the line control and status block
// Assumes ulc_pkg, the ulc_uart core and the serial peer model
`timescale 1ns/1ps
module test_uart_line_control_status;
   import ulc_pkg::*;
   logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdat;
   logic        pready, pslverr, serial_input, serial_output, irq, rerr;
   int          mismatches = 0, n_tests = 0;
   logic [7:0]  lc, d;
   int          n, pn, base, k;
   // ==========================================================
   // Clock, design and peer
   always #5 ref_clk = ~ref_clk;
   ulc_uart i_ulc_uart (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_input(serial_input), .serial_output(serial_output),
      .irq(irq));
   ulc_peer i_peer (.ref_clk(ref_clk), .serial_output(serial_output),
      .serial_input(serial_input));
   // ==========================================================
   // Value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // One APB transfer, setup then access until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int w;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge ref_clk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      if (w >= 50) chk(0, 1, "apb hang");
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      apb(1'b1, a, {24'h0, v});
   endtask : wr
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // Poll until the transmit register is free again
   task automatic wait_tx_reg_empty_flag();
      k = 0;
      rd(ULC_OFF_LSR);
      while (rdat[ULC_LS_TX_REG_EMPTY_FLAG] !== 1'b1 && k < 50) begin
         rd(ULC_OFF_LSR);
         k++;
      end
      chk(rdat & 32'h40, 32'h40, "tx empty");
   endtask : wait_tx_reg_empty_flag
   // ==========================================================
   // Expected frame: start, data, parity, first stop
   function automatic logic [31:0] exp_frame(logic [7:0] v, int nb, logic [7:0] c);
      logic [31:0] f;
      logic        p;
      f = '0;
      for (int i = 0; i < nb; i++) f[i+1] = v[i];
      p = c[ULC_LC_STK] ? c[ULC_LC_EVN] : (^(v & (8'hff >> (8 - nb))) ^ !c[ULC_LC_EVN]);
      if (c[ULC_LC_PEN]) f[nb+1] = p;
      f[nb + c[ULC_LC_PEN] + 1] = 1'b1;
      return f;
   endfunction : exp_frame
   function automatic int exp_gap(int nb, logic [7:0] c);
      return 16 * (1 + nb + c[ULC_LC_PEN]) + (c[ULC_LC_STOP] ? (nb == 5 ? 24 : 32) : 16);
   endfunction : exp_gap
   // ==========================================================
   // Verdict and end of run
   task automatic print_verdict();
      $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial begin
      #800000;
      mismatches++;
      print_verdict();
   end
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(90));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(ULC_OFF_LCR);
      chk(rdat, {24'h0, ULC_LCR_RST}, "lcr reset");
      rd(ULC_OFF_LSR);
      chk(rdat, 32'h60, "lsr reset");
      rd(8'h18);
      chk({rdat[30:0], rerr}, 32'h1, "unmapped");
      // Divisor access leaves data path alone
      wr(ULC_OFF_LCR, 8'h80);
      wr(ULC_OFF_DATA, 8'h01);
      wr(ULC_OFF_DIVHI, 8'h00);
      rd(ULC_OFF_DATA);
      chk(rdat, 32'h01, "div low");
      rd(ULC_OFF_LSR);
      chk(rdat & 32'h60, 32'h60, "no tx on divisor");
      // Transmit formats, two frames back to back
      for (int i = 0; i < 8; i++) begin
         lc = {2'b00, 3'($urandom), i[2], i[1:0]};
         d = 8'($urandom);
         n = 5 + i % 4;
         pn = lc[ULC_LC_PEN];
         i_peer.nbits = n;
         i_peer.parity_enable = pn;
         wr(ULC_OFF_LCR, lc);
         base = i_peer.nfr;
         wr(ULC_OFF_DATA, d);
         wr(ULC_OFF_DATA, ~d);
         k = 0;
         while (i_peer.nfr < base + 2 && k < 2000) begin
            @(posedge ref_clk);
            k++;
         end
         wait_tx_reg_empty_flag();
         chk({20'h0, i_peer.got}, exp_frame(~d, n, lc), "tx frame");
         chk(32'(i_peer.gap), 32'(exp_gap(n, lc)), "frame length");
      end
      // Receive: good char, bad parity with interrupt
      wr(ULC_OFF_LCR, 8'h1b);
      wr(ULC_OFF_IEN, 8'h04);
      wr(ULC_OFF_IRQMK, 8'h01);
      d = 8'($urandom);
      i_peer.send(d, 8, ^d, 1'b1);
      rd(ULC_OFF_LSR);
      chk(rdat, 32'h41, "rx ready");
      rd(ULC_OFF_DATA);
      chk(rdat, {24'h0, d}, "rx data");
      rd(ULC_OFF_LSR);
      chk(rdat, 32'h60, "rx drained");
      i_peer.send(d, 8, ~^d, 1'b1);
      chk({31'h0, irq}, 32'h1, "irq on error");
      rd(ULC_OFF_LSR);
      chk(rdat & 32'h0e, 32'h04, "parity error");
      rd(ULC_OFF_IRQST);
      chk(rdat & 32'h1, 32'h1, "irq status");
      chk({31'h0, irq}, 32'h0, "irq cleared");
      rd(ULC_OFF_DATA);
      // Bad stop with interrupt masked
      wr(ULC_OFF_IRQMK, 8'h00);
      i_peer.send(d, 8, ^d, 1'b0);
      chk({31'h0, irq}, 32'h0, "irq masked");
      rd(ULC_OFF_LSR);
      chk(rdat & 32'h08, 32'h08, "framing error");
      rd(ULC_OFF_LSR);
      chk(rdat & 32'h1e, 32'h0, "flags cleared");
      rd(ULC_OFF_DATA);
      // Two stops set, peer sends one: no framing error, overrun
      wr(ULC_OFF_LCR, 8'h1f);
      i_peer.send(d, 8, ^d, 1'b1);
      i_peer.send(~d, 8, ~^d, 1'b1);
      rd(ULC_OFF_LSR);
      chk(rdat & 32'h0b, 32'h03, "overrun only");
      rd(ULC_OFF_DATA);
      chk(rdat, {24'h0, ~d}, "overwritten");
      // Forced break on the transmit line
      wr(ULC_OFF_LCR, 8'h43);
      repeat (40) @(posedge ref_clk);
      chk({31'h0, serial_output}, 32'h0, "break out");
      wr(ULC_OFF_LCR, 8'h03);
      repeat (4) @(posedge ref_clk);
      chk({31'h0, serial_output}, 32'h1, "break off");
      // Long low receive line
      i_peer.hold_low(16 * 14);
      repeat (40) @(posedge ref_clk);
      rd(ULC_OFF_LSR);
      chk(rdat & 32'h10, 32'h10, "break detect");
      rd(ULC_OFF_LSR);
      chk(rdat & 32'h1e, 32'h0, "break cleared");
      print_verdict();
   end
endmodule : test_uart_line_control_status
